// File: inc/bdu_pkg.sv
// Package with opcodes, flag positions and cycle counts for the unit.
package bdu_pkg;
  localparam logic [7:0] OPC_BCD_R   = 8'h40;
  localparam logic [7:0] OPC_BCD_IR  = 8'h41;
  localparam logic [7:0] OPC_DECB_R  = 8'h00;
  localparam logic [7:0] OPC_DECB_IR = 8'h01;
  localparam logic [7:0] OPC_WORD_MINUS_ONE_OP_RR = 8'h80;
  localparam logic [7:0] OPC_WORD_MINUS_ONE_OP_IR = 8'h81;
  localparam logic [7:0] OPC_IRQOFF  = 8'h8f;
  localparam logic [7:0] OPC_DIV_R   = 8'h94;
  localparam logic [7:0] OPC_DIV_IR  = 8'h95;
  localparam logic [7:0] OPC_DIV_IM  = 8'h96;
  localparam int FLG_C = 7;
  localparam int FLG_Z = 6;
  localparam int FLG_S = 5;
  localparam int FLG_V = 4;
  localparam int FLG_D = 3;
  localparam int FLG_H = 2;
  localparam int SYM_IE = 0;
  localparam logic [7:0] SYM_RST = 8'h00;
  localparam logic [7:0] FLG_RST = 8'h00;
  localparam logic [4:0] CYC_SHORT   = 5'h04;
  localparam logic [4:0] CYC_WORD    = 5'h08;
  localparam logic [4:0] CYC_DIV0    = 5'h0a;
  localparam logic [4:0] CYC_DIV     = 5'h1a;
  localparam logic [4:0] DIV_STEPS   = 5'h10;
  localparam logic [7:0] ADJ_06 = 8'h06;
  localparam logic [7:0] ADJ_60 = 8'h60;
  localparam logic [7:0] ADJ_66 = 8'h66;
  localparam logic [7:0] ADJ_FA = 8'hfa;
  localparam logic [7:0] ADJ_A0 = 8'ha0;
  localparam logic [7:0] ADJ_9A = 8'h9a;
  localparam int NUM_IRQ = 8;
  typedef enum logic [2:0] {
    BDU_IDLE = 3'b001,
    BDU_BUSY = 3'b010,
    BDU_DONE = 3'b100
  } bdu_state_t;
endpackage

// File: rtl/bdu_divider.sv
// Restoring 16-by-8 unsigned divider, one quotient bit per enabled cycle.
`timescale 1ns/1ps
module bdu_divider
  import bdu_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        en_i,
  input  wire logic        start_i,
  input  wire logic [15:0] dividend_i,
  input  wire logic [7:0]  divisor_i,
  output logic [8:0]       quot_o,
  output logic [7:0]       rem_o
);
  // A 9-bit quotient is kept so that carry can tell 256..511 from 0..255.
  logic [16:0] acc_ff;
  logic [15:0] sh_ff;
  logic [8:0]  q_ff;
  logic [16:0] trial;
  logic        fits;
  logic [16:0] nxt_acc;
  logic [4:0]  step_ff;
  logic        run;

  // Stop after sixteen steps, or extra shifts would wreck the remainder.
  assign run     = (step_ff != 5'h00);
  assign trial   = {acc_ff[15:0], sh_ff[15]};
  assign fits    = trial >= {9'h000, divisor_i};
  assign nxt_acc = fits ? trial - {9'h000, divisor_i} : trial;
  assign quot_o  = q_ff;
  assign rem_o   = acc_ff[7:0];

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      acc_ff <= 17'h00000;
      sh_ff  <= 16'h0000;
      q_ff   <= 9'h000;
      step_ff <= 5'h00;
    end else if (en_i && start_i) begin
      acc_ff <= 17'h00000;
      sh_ff  <= dividend_i;
      q_ff   <= 9'h000;
      step_ff <= DIV_STEPS;
    end else if (en_i && run) begin
      acc_ff <= nxt_acc;
      sh_ff  <= {sh_ff[14:0], 1'b0};
      q_ff   <= {q_ff[7:0], fits};
      step_ff <= step_ff - 5'h01;
    end
  end
endmodule

// File: rtl/bdu_exec.sv
// Execution unit for decimal adjust, decrements, irq disable and divide.
`timescale 1ns/1ps
module bdu_exec
  import bdu_pkg::*;
(
  input  wire logic         clk_i,
  input  wire logic         rstn_i,
  input  wire logic         ce_i,
  input  wire logic         start_i,
  input  wire logic [7:0]   opcode_i,
  input  wire logic         prev_sub_i,
  input  wire logic [15:0]  dst_i,
  input  wire logic [7:0]   src_i,
  input  wire logic [7:0]   flags_i,
  input  wire logic         irq_on_i,
  input  wire logic [7:0]   irq_req_i,
  input  wire logic [7:0]   irq_clr_i,
  output logic              busy_o,
  output logic              done_o,
  output logic              illegal_o,
  output logic [15:0]       result_o,
  output logic              wr_word_o,
  output logic [7:0]        flags_o,
  output logic              sym_ie_o,
  output logic [7:0]        irq_pend_o,
  output logic [7:0]        irq_take_o
);
  bdu_state_t  state_ff;
  bdu_state_t  nxt_state;
  logic [4:0]  cnt_ff;
  logic [4:0]  nxt_cnt;
  logic [7:0]  op_ff;
  logic [15:0] dst_ff;
  logic [7:0]  src_ff;
  logic        sub_ff;
  logic [7:0]  flg_in_ff;
  logic [7:0]  flags_ff;
  logic [15:0] result_ff;
  logic        wr_word_ff;
  logic        done_ff;
  logic        busy_ff;
  logic        illegal_ff;
  logic        sym_ie_ff;
  logic [7:0]  pend_ff;
  logic [7:0]  take_ff;
  logic [7:0]  req_m_ff;
  logic [7:0]  req_s_ff;

  // Opcode decode.
  wire is_bcd  = (opcode_i == OPC_BCD_R)   || (opcode_i == OPC_BCD_IR);
  wire is_decb = (opcode_i == OPC_DECB_R)  || (opcode_i == OPC_DECB_IR);
  wire is_word_minus_one_op = (opcode_i == OPC_WORD_MINUS_ONE_OP_RR) || (opcode_i == OPC_WORD_MINUS_ONE_OP_IR);
  wire is_off  = (opcode_i == OPC_IRQOFF);
  wire is_div  = (opcode_i == OPC_DIV_R) || (opcode_i == OPC_DIV_IR) ||
                 (opcode_i == OPC_DIV_IM);
  wire legal   = is_bcd | is_decb | is_word_minus_one_op | is_off | is_div;
  wire take    = start_i && (state_ff == BDU_IDLE) && legal;

  wire op_bcd  = (op_ff == OPC_BCD_R)   || (op_ff == OPC_BCD_IR);
  wire op_decb = (op_ff == OPC_DECB_R)  || (op_ff == OPC_DECB_IR);
  wire op_word_minus_one_op = (op_ff == OPC_WORD_MINUS_ONE_OP_RR) || (op_ff == OPC_WORD_MINUS_ONE_OP_IR);
  wire op_off  = (op_ff == OPC_IRQOFF);
  wire op_div  = (op_ff == OPC_DIV_R) || (op_ff == OPC_DIV_IR) ||
                 (op_ff == OPC_DIV_IM);

  // Cycle count per instruction; the divisor decides the divide length.
  // four cycles for short ops, eight for word decrement, 10 or 26 for divide
  wire [4:0] cyc_len = is_word_minus_one_op ? CYC_WORD :
                       is_div  ? ((src_i == 8'h00) ? CYC_DIV0 : CYC_DIV) :
                                 CYC_SHORT;

  // Decimal adjust correction select.
  wire       c_in   = flg_in_ff[FLG_C];
  wire       h_in   = flg_in_ff[FLG_H];
  wire [3:0] hi_nib = dst_ff[7:4];
  wire [3:0] lo_nib = dst_ff[3:0];
  wire       lo_big = lo_nib > 4'h9;
  wire add_lo   = h_in | lo_big;
  wire add_hi   = c_in | (hi_nib > 4'h9) | ((hi_nib > 4'h8) & lo_big);
  wire [7:0] add_k = {add_hi ? ADJ_60[7:4] : 4'h0,
                      add_lo ? ADJ_06[3:0] : 4'h0};
  wire [7:0] sub_k = (c_in & h_in) ? ADJ_9A :
                     c_in          ? ADJ_A0 :
                     h_in          ? ADJ_FA : 8'h00;
  wire [7:0] bcd_k = sub_ff ? sub_k : add_k;
  wire [7:0] bcd_r = dst_ff[7:0] + bcd_k;
  wire       bcd_c = sub_ff ? c_in : add_hi;

  wire [7:0]  decb_r = dst_ff[7:0] - 8'h01;
  wire [15:0] word_minus_one_op_r = dst_ff - 16'h0001;
  wire decb_v = (dst_ff[7:0] == 8'h80);
  wire word_minus_one_op_v = (dst_ff == 16'h8000);

  logic [8:0] quot;
  logic [7:0] rem;
  bdu_divider u_div (
    .clk_i      (clk_i),
    .rstn_i     (rstn_i),
    .en_i       (ce_i),
    .start_i    (take),
    .dividend_i (dst_i),
    .divisor_i  (src_i),
    .quot_o     (quot),
    .rem_o      (rem)
  );
  wire div_zero = (src_ff == 8'h00);
  // Quotient bits above bit 8 never enter the 9-bit quotient; catch them here.
  wire div_huge = (dst_ff[15:8] >= {src_ff[6:0], 1'b0}) && !src_ff[7];
  wire div_v = div_zero | div_huge | quot[8];
  wire div_c = !div_zero && !div_huge && quot[8];

  // Result mux and flag build for the final cycle.
  logic [15:0] nxt_result;
  logic [7:0]  nxt_flags;
  logic        nxt_word;
  always_comb begin
    nxt_result = result_ff;
    nxt_flags  = flg_in_ff;
    nxt_word   = 1'b0;
    if (op_bcd) begin
      nxt_result = {8'h00, bcd_r};
      nxt_flags[FLG_C] = bcd_c;
      nxt_flags[FLG_Z] = (bcd_r == 8'h00);
      nxt_flags[FLG_S] = bcd_r[7];
    end else if (op_decb) begin
      nxt_result = {8'h00, decb_r};
      nxt_flags[FLG_Z] = (decb_r == 8'h00);
      nxt_flags[FLG_S] = decb_r[7];
      nxt_flags[FLG_V] = decb_v;
    end else if (op_word_minus_one_op) begin
      nxt_result = word_minus_one_op_r;
      nxt_word   = 1'b1;
      nxt_flags[FLG_Z] = (word_minus_one_op_r == 16'h0000);
      nxt_flags[FLG_S] = word_minus_one_op_r[15];
      nxt_flags[FLG_V] = word_minus_one_op_v;
    end else if (op_div) begin
      nxt_result = {rem, quot[7:0]};
      nxt_word   = 1'b1;
      nxt_flags[FLG_C] = div_c;
      nxt_flags[FLG_Z] = div_zero | (quot[7:0] == 8'h00 && !div_v);
      nxt_flags[FLG_S] = quot[7];
      nxt_flags[FLG_V] = div_v;
    end
  end

  wire last = (state_ff == BDU_BUSY) && (cnt_ff == 5'h01);

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    unique case (state_ff)
      BDU_IDLE: begin
        if (take) begin
          nxt_state = BDU_BUSY;
          nxt_cnt   = cyc_len - 5'h01;
        end
      end
      BDU_BUSY: begin
        nxt_cnt = cnt_ff - 5'h01;
        if (last) begin
          nxt_state = BDU_DONE;
        end
      end
      BDU_DONE: begin
        nxt_state = BDU_IDLE;
      end
      default: begin
        nxt_state = BDU_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_ff <= BDU_IDLE;
      cnt_ff   <= 5'h00;
    end else if (ce_i) begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      op_ff     <= 8'h00;
      dst_ff    <= 16'h0000;
      src_ff    <= 8'h00;
      sub_ff    <= 1'b0;
      flg_in_ff <= FLG_RST;
    end else if (ce_i && take) begin
      op_ff     <= opcode_i;
      dst_ff    <= dst_i;
      src_ff    <= src_i;
      sub_ff    <= prev_sub_i;
      flg_in_ff <= flags_i;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      result_ff  <= 16'h0000;
      flags_ff   <= FLG_RST;
      wr_word_ff <= 1'b0;
      done_ff    <= 1'b0;
    end else if (ce_i) begin
      done_ff <= last;
      if (last) begin
        result_ff  <= nxt_result;
        flags_ff   <= nxt_flags;
        wr_word_ff <= nxt_word;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      busy_ff    <= 1'b0;
      illegal_ff <= 1'b0;
    end else if (ce_i) begin
      busy_ff    <= (nxt_state == BDU_BUSY);
      illegal_ff <= start_i && (state_ff == BDU_IDLE) && !legal;
    end
  end

  wire nxt_ie = (last && op_off) ? 1'b0 : (irq_on_i ? 1'b1 : sym_ie_ff);
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sym_ie_ff <= SYM_RST[SYM_IE];
    end else if (ce_i) begin
      sym_ie_ff <= nxt_ie;
    end
  end

  // Requests arrive from pins, so they pass two flops first.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      req_m_ff <= 8'h00;
      req_s_ff <= 8'h00;
    end else if (ce_i) begin
      req_m_ff <= irq_req_i;
      req_s_ff <= req_m_ff;
    end
  end

  // pending always latches
  // Set wins over clear so a request in the clear cycle survives.
  genvar g;
  generate
    for (g = 0; g < NUM_IRQ; g++) begin : g_irq
      always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          pend_ff[g] <= 1'b0;
          take_ff[g] <= 1'b0;
        end else if (ce_i) begin
          pend_ff[g] <= req_s_ff[g] | (pend_ff[g] & ~irq_clr_i[g]);
          take_ff[g] <= pend_ff[g] & sym_ie_ff;
        end
      end
    end
  endgenerate

  assign busy_o     = busy_ff;
  assign done_o     = done_ff;
  assign illegal_o  = illegal_ff;
  assign result_o   = result_ff;
  assign wr_word_o  = wr_word_ff;
  assign flags_o    = flags_ff;
  assign sym_ie_o   = sym_ie_ff;
  assign irq_pend_o = pend_ff;
  assign irq_take_o = take_ff;

  chk_decb_len: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ce_i && take && is_decb |=> (ce_i [*3]) ##1 done_o)
    else $error("byte decrement length wrong");
  chk_word_minus_one_op_len: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ce_i && take && is_word_minus_one_op |=> (ce_i [*7]) ##1 done_o)
    else $error("word decrement length wrong");
  chk_div0_len: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ce_i && take && is_div && src_i == 8'h00 |=> (ce_i [*8]) ##2 done_o)
    else $error("divide by zero length wrong");
  chk_div0_flag: assert property (@(posedge clk_i) disable iff (!rstn_i)
    done_o && op_div && div_zero |-> flags_o[FLG_V] && flags_o[FLG_Z])
    else $error("divide by zero flags wrong");
  chk_div_carry: assert property (@(posedge clk_i) disable iff (!rstn_i)
    done_o && op_div && flags_o[FLG_C] |-> flags_o[FLG_V])
    else $error("divide carry without overflow");
  chk_decb_keep: assert property (@(posedge clk_i) disable iff (!rstn_i)
    done_o && op_decb |-> flags_o[FLG_C] == flg_in_ff[FLG_C] &&
    result_o[7:0] == dst_ff[7:0] - 8'h01)
    else $error("byte decrement result or carry wrong");
  chk_bcd_keep: assert property (@(posedge clk_i) disable iff (!rstn_i)
    done_o && op_bcd |-> flags_o[FLG_H] == flg_in_ff[FLG_H] &&
    flags_o[FLG_Z] == (result_o[7:0] == 8'h00))
    else $error("adjust flags wrong");
  chk_off_clear: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ce_i && last && op_off && !irq_on_i |=> !sym_ie_o)
    else $error("irq disable did not clear enable");
  chk_no_serve: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ce_i && !sym_ie_o |=> irq_take_o == 8'h00)
    else $error("irq serviced while disabled");
  cov_div: cover property (@(posedge clk_i) done_o && op_div);
  cov_bcd_sub: cover property (@(posedge clk_i) done_o && op_bcd && sub_ff);
  cov_word_minus_one_op: cover property (@(posedge clk_i) done_o && op_word_minus_one_op);
endmodule

// File: tb/tb.sv
// Self-checking bench for the decimal adjust, decrement and divide unit.
`timescale 1ns/1ps
module tb;
  import bdu_pkg::*;

  `define CHK(got, exp) begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
      miscompares++; \
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); \
    end \
  end

  logic        clk_i;
  logic        rstn_i;
  logic        ce_i;
  logic        start_i;
  logic [7:0]  opcode_i;
  logic        prev_sub_i;
  logic [15:0] dst_i;
  logic [7:0]  src_i;
  logic [7:0]  flags_i;
  logic        irq_on_i;
  logic [7:0]  irq_req_i;
  logic [7:0]  irq_clr_i;
  logic        busy_o;
  logic        done_o;
  logic        illegal_o;
  logic [15:0] result_o;
  logic        wr_word_o;
  logic [7:0]  flags_o;
  logic        sym_ie_o;
  logic [7:0]  irq_pend_o;
  logic [7:0]  irq_take_o;
  int          samples_checked = 0;
  int          miscompares = 0;
  int          cycle_count = 0;
  int          n;
  logic [19:0] t;
  logic [55:0] c;
  logic [7:0]  fi;
  logic [7:0]  e8;
  logic [7:0]  msk;
  logic [7:0]  op;
  logic [15:0] e16;

  // valid BCD and non-BCD inputs
  // Packed as {prev_sub, carry, half, carry_after, input, output}.
  logic [19:0] da_tab [13] = '{20'h03c42, 20'h1a505, 20'h22228, 20'h19a00,
    20'h51272, 20'h52a90, 20'h73197, 20'h04545, 20'h3a208, 20'h83131,
    20'ha0f09, 20'hd9030, 20'hf6600};
  // Packed as {dividend, divisor, result, flags, cycles}.
  logic [55:0] dv_tab [6] = '{56'h1003_40_0340_00_1a,
    56'h0080_01_0080_20_1a, 56'h0005_07_0500_40_1a,
    56'h1234_00_0000_50_0a, 56'h0100_01_0000_90_1a,
    56'hffff_01_0000_10_1a};
  logic [7:0]  bv [4] = '{8'h00, 8'h80, 8'h01, 8'h34};
  logic [15:0] wv [4] = '{16'h0000, 16'h8000, 16'h0001, 16'h1200};

  bdu_exec i_dut (
    .clk_i      (clk_i),
    .rstn_i     (rstn_i),
    .ce_i       (ce_i),
    .start_i    (start_i),
    .opcode_i   (opcode_i),
    .prev_sub_i (prev_sub_i),
    .dst_i      (dst_i),
    .src_i      (src_i),
    .flags_i    (flags_i),
    .irq_on_i   (irq_on_i),
    .irq_req_i  (irq_req_i),
    .irq_clr_i  (irq_clr_i),
    .busy_o     (busy_o),
    .done_o     (done_o),
    .illegal_o  (illegal_o),
    .result_o   (result_o),
    .wr_word_o  (wr_word_o),
    .flags_o    (flags_o),
    .sym_ie_o   (sym_ie_o),
    .irq_pend_o (irq_pend_o),
    .irq_take_o (irq_take_o)
  );

  always #25 clk_i = ~clk_i;

  task automatic print_verdict;
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // The ceiling is far above the few hundred cycles the tests need.
  always @(posedge clk_i) begin
    cycle_count++;
    if (cycle_count == 20000) begin
      miscompares++;
      print_verdict;
    end
  end

  // Counts only enabled edges, since a low enable freezes the unit.
  task automatic exec(input logic [7:0] o, input logic ps,
                      input logic [15:0] d, input logic [7:0] s,
                      input logic [7:0] f, input bit hold, input bit gap,
                      output int cnt);
    @(posedge clk_i);
    #5;
    start_i = 1'b1;
    opcode_i = o;
    prev_sub_i = ps;
    dst_i = d;
    src_i = s;
    flags_i = f;
    @(posedge clk_i);
    #5;
    start_i = hold;
    `CHK(busy_o, 1'b1)
    // The take edge is the first cycle of the instruction.
    cnt = 1;
    if (gap) ce_i = 1'b0;
    repeat (100) begin
      @(posedge clk_i);
      if (ce_i) cnt++;
      #5;
      if (done_o === 1'b1) break;
      if (gap) ce_i = ~ce_i;
    end
    start_i = 1'b0;
    ce_i = 1'b1;
    `CHK({busy_o, done_o}, 2'b01)
  endtask

  initial begin
    clk_i = 1'b0;
    rstn_i = 1'b0;
    ce_i = 1'b1;
    start_i = 1'b0;
    opcode_i = 8'h00;
    prev_sub_i = 1'b0;
    dst_i = 16'h0000;
    src_i = 8'h00;
    flags_i = 8'h00;
    irq_on_i = 1'b0;
    irq_req_i = 8'h00;
    irq_clr_i = 8'h00;
    repeat (8) @(posedge clk_i);
    #5 rstn_i = 1'b1;
    `CHK({busy_o, done_o, sym_ie_o, flags_o, irq_pend_o}, 19'h0)
    for (int i = 0; i < 13; i++) begin
      t = da_tab[i];
      fi = {t[18], 4'h0, t[17], 2'b00} | (i[0] ? 8'h08 : 8'h00);
      exec(i[0] ? OPC_BCD_IR : OPC_BCD_R, t[19], {8'h00, t[15:8]}, 8'h00,
           fi, 1'b0, 1'b0, n);
      `CHK(n, 4)
      `CHK(result_o[7:0], t[7:0])
      `CHK(flags_o & 8'hec, {t[16], t[7:0] == 8'h00, t[7], 5'h0} | (fi & 8'h0c))
    end
    $display("test decimal adjust done");
    for (int i = 0; i < 4; i++) begin
      fi = i[0] ? 8'h8c : 8'h04;
      exec(i[0] ? OPC_DECB_IR : OPC_DECB_R, 1'b0, {8'h00, bv[i]}, 8'h00,
           fi, 1'b0, 1'b0, n);
      e8 = bv[i] - 8'h01;
      `CHK(n, 4)
      `CHK({wr_word_o, result_o}, {9'h000, e8})
      `CHK(flags_o & 8'hfc, {fi[7], e8 == 8'h00, e8[7], bv[i] == 8'h80, fi[3:2], 2'b00})
      exec(i[0] ? OPC_WORD_MINUS_ONE_OP_IR : OPC_WORD_MINUS_ONE_OP_RR, 1'b0, wv[i], 8'h00,
           fi, 1'b0, 1'b0, n);
      e16 = wv[i] - 16'h0001;
      `CHK(n, 8)
      `CHK({wr_word_o, result_o}, {1'b1, e16})
      `CHK(result_o[15:8] | result_o[7:0], e16[15:8] | e16[7:0])
      `CHK(flags_o & 8'hfc, {fi[7], e16 == 16'h0, e16[15], wv[i] == 16'h8000, fi[3:2], 2'b00})
    end
    $display("test decrement done");
    @(posedge clk_i);
    #5 irq_on_i = 1'b1;
    @(posedge clk_i);
    #5 irq_on_i = 1'b0;
    `CHK(sym_ie_o, 1'b1)
    exec(OPC_IRQOFF, 1'b0, 16'h0000, 8'h00, 8'ha4, 1'b0, 1'b0, n);
    `CHK({n[4:0], sym_ie_o, flags_o}, {5'h04, 1'b0, 8'ha4})
    irq_req_i = 8'h24;
    repeat (4) @(posedge clk_i);
    #5;
    `CHK({irq_pend_o, irq_take_o}, 16'h2400)
    irq_req_i = 8'h00;
    irq_on_i = 1'b1;
    @(posedge clk_i);
    #5 irq_on_i = 1'b0;
    @(posedge clk_i);
    #5;
    `CHK(irq_take_o, 8'h24)
    exec(OPC_IRQOFF, 1'b0, 16'h0000, 8'h00, 8'h00, 1'b0, 1'b0, n);
    irq_clr_i = 8'h24;
    @(posedge clk_i);
    #5 irq_clr_i = 8'h00;
    @(posedge clk_i);
    #5;
    `CHK({irq_pend_o, irq_take_o}, 16'h0000)
    $display("test interrupt disable done");
    // An unknown opcode must be refused without starting a run.
    start_i = 1'b1;
    opcode_i = 8'h55;
    @(posedge clk_i);
    #5 start_i = 1'b0;
    `CHK({illegal_o, busy_o}, 2'b10)
    for (int i = 0; i < 6; i++) begin
      c = dv_tab[i];
      op = (i % 3 == 0) ? OPC_DIV_R : ((i % 3 == 1) ? OPC_DIV_IR : OPC_DIV_IM);
      exec(op, 1'b0, c[55:40], c[39:32], 8'h0c, i == 1, i == 2, n);
      msk = c[12] ? 8'hdc : 8'hfc;
      `CHK(n, int'(c[7:0]))
      `CHK(flags_o & msk, c[15:8] | 8'h0c)
      if (!c[12]) `CHK({wr_word_o, result_o}, {1'b1, c[31:16]})
    end
    $display("test divide done");
    print_verdict;
  end
endmodule
